//--- rtl/peoa_defs.svh
// constants for the pre-echo onset refine and attenuate block
`ifndef PEOA_DEFS_SVH
`define PEOA_DEFS_SVH
`define PEOA_NUM_SUB 8
`define PEOA_SUB_MS_X10 25
`define PEOA_FRAME_MAX 640
`define PEOA_ZCR_LIM_NB 10
`define PEOA_ZCR_LIM_WB 16
`define PEOA_NSSF_8K 4
`define PEOA_NSSF_WIDE 8
`define PEOA_PEAK_DIV 8
`define PEOA_MCRIT_DIV 80
`define PEOA_SUM_MUL 4
`define PEOA_SMOOTH_NB 20
`define PEOA_SMOOTH_WB 4
`define PEOA_GAIN_ONE 16'h7FFF
`define PEOA_GAIN_RESET 16'h7FFF
`endif

//--- rtl/peoa_pkg.sv
// types shared by the pre-echo onset refine and attenuate block
package peoa_pkg;
    typedef enum logic [2:0] {
        PEOA_IDLE = 3'b000,
        PEOA_LOAD = 3'b001,
        PEOA_ENER = 3'b011,
        PEOA_REFN = 3'b010,
        PEOA_APPL = 3'b110
    } peoa_state_e;
    typedef logic signed [15:0] peoa_sample_t;
    typedef logic [15:0] peoa_gain_t;
    typedef logic [39:0] peoa_energy_t;
endpackage

//--- rtl/peoa_gain_smoother.sv
// low-band gain linear smoother across sub-block steps
`timescale 1ns/10ps
`include "peoa_defs.svh"
module peoa_gain_smoother
    import peoa_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic narrowBand,
    input wire logic stepStart,
    input wire logic sampleValid,
    input wire peoa_gain_t oldGain,
    input wire peoa_gain_t newGain,
    output peoa_gain_t smoothGain
);
    logic [4:0] pos;
    logic [4:0] next_pos;
    logic [4:0] len;
    logic [35:0] num;

    // position counter inside a transition
    always_comb begin
        len = narrowBand ? 5'(`PEOA_SMOOTH_NB) : 5'(`PEOA_SMOOTH_WB);
        next_pos = pos;
        if (sampleValid) begin
            if (stepStart) begin
                next_pos = 5'd1;
            end else if (pos != 5'd0 && pos < len) begin
                next_pos = pos + 5'd1;
            end else begin
                next_pos = 5'd0;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pos <= 5'd0;
        end else begin
            pos <= next_pos;
        end
    end

    // weights (len+1-k):k over len+1, k = 1..len
    always_comb begin
        logic [4:0] k;
        k = stepStart ? 5'd1 : pos + 5'd1;
        num = 36'(6'(len) + 6'd1 - 6'(k)) * 36'(oldGain) + 36'(k) * 36'(newGain);
        if (stepStart || (pos != 5'd0 && pos < len)) begin
            smoothGain = 16'(num / 36'(len + 5'd1));
        end else begin
            smoothGain = newGain;
        end
    end

    property p_unity_steady;
        @(posedge mclk) disable iff (reset)
            (sampleValid && oldGain == 16'h7FFF && newGain == 16'h7FFF) |-> smoothGain == 16'h7FFF;
    endproperty
    a_unity_steady: assert property (p_unity_steady)
        else $error("unity gains did not smooth to unity");
endmodule

//--- rtl/peoa_mixer.sv
// two band gain multiply and sum
`timescale 1ns/10ps
module peoa_mixer
    import peoa_pkg::*;
(
    input wire peoa_sample_t lowSample,
    input wire peoa_sample_t highSample,
    input wire peoa_gain_t lowGain,
    input wire peoa_gain_t highGain,
    output peoa_sample_t mixSample
);
    logic signed [32:0] lowProd;
    logic signed [32:0] highProd;
    logic signed [33:0] total;

    // gains are Q1.15, products summed then rescaled
    always_comb begin
        lowProd = 33'(lowSample) * 33'($signed({1'b0, lowGain}));
        highProd = 33'(highSample) * 33'($signed({1'b0, highGain}));
        total = 34'(lowProd) + 34'(highProd);
        mixSample = 16'(total >>> 15);
    end
endmodule

//--- rtl/peoa_top.sv
// pre-echo onset refinement, false-alarm check and two band attenuation
// What this block does
// - frame is eight equal sub-blocks plus one look-ahead memory sub-block.
// - zero-crossing limit is 10 for narrowband, 16 otherwise.
// - sub-block splits into 4 sub-sub-blocks at 8 kHz, else 8.
// - in-frame onset: energies from onset sub-block to end; index zero: first only.
// - memory onset: one sub-block of memory samples is examined.
// - first threshold is largest sub-sub-block energy divided by 8.
// - second threshold is max(noise, (ref + 4*earlier sum)/(j+1)).
// - reference is last pre-echo energy times gain, or peak/80 if larger and zero-crossings exceed the limit.
// - onset advances per sub-sub-block while energy under both thresholds.
// - moved samples take last pre-echo gain and join that sub-block.
// - onset in first or second sub-block skips the regression check.
// - onset in third sub-block: negative high-band slope inhibits.
// - later onset: negative full-band three-block slope inhibits.
// - later onset: high-band slope under 2/15 of three-block sum inhibits.
// - low-band smoothing uses 20 levels narrowband, 4 otherwise.
// - each gain step gets linear old-to-new weights over length plus one.
// - first sub-block smooths from last gain kept from previous frame.
// - onset in next frame: no smoothing at frame end, defer.
// - high-band initial gain is used unsmoothed.
// - output is sum of gained low-band and high-band samples.
`timescale 1ns/10ps
`include "peoa_defs.svh"
module peoa_top
    import peoa_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic frameStart,
    input wire logic narrowBand,
    input wire logic rate8k,
    input wire logic [9:0] subLen,
    input wire logic [3:0] onset_subblock_index,
    input wire peoa_energy_t peak_subblock_energy,
    input wire peoa_energy_t prevNoiseEnergy,
    input wire peoa_energy_t fullEnergy [0:8],
    input wire peoa_energy_t highEnergy [0:7],
    input wire logic [7:0] zcrCount [0:8],
    input wire peoa_gain_t lowInitGain [0:7],
    input wire peoa_gain_t highband_initial_gain [0:7],
    input wire logic inValid,
    input wire peoa_sample_t lowband_signal,
    input wire peoa_sample_t highband_signal,
    input wire peoa_sample_t fullSample,
    output logic busy,
    output logic outValid,
    output peoa_sample_t outSample,
    output logic inhibit,
    output logic [9:0] refinedOnset
);
    localparam int NSUB = `PEOA_NUM_SUB;
    localparam int FMAX = `PEOA_FRAME_MAX;

    peoa_state_e state;
    peoa_state_e next_state;
    peoa_sample_t fullBuf [0:FMAX-1];
    peoa_sample_t lowBuf [0:FMAX-1];
    peoa_sample_t highBuf [0:FMAX-1];
    peoa_sample_t memBuf [0:(FMAX/NSUB)-1];
    logic [10:0] cnt;
    logic [10:0] next_cnt;
    peoa_energy_t acc;
    peoa_energy_t next_acc;
    peoa_energy_t esum;
    peoa_energy_t next_esum;
    peoa_energy_t eMax;
    peoa_energy_t next_eMax;
    peoa_energy_t eshr [0:63];
    logic [6:0] nSsf;
    logic [6:0] next_nSsf;
    logic [9:0] onsetPos;
    logic [9:0] next_onsetPos;
    logic stopAdv;
    logic next_stopAdv;
    logic inhib;
    logic next_inhib;
    peoa_gain_t lastGain;
    peoa_gain_t next_lastGain;
    logic [5:0] j;
    logic [9:0] lssf;
    logic [9:0] frameLen;
    logic [3:0] ssfCount;
    logic memOnset;
    peoa_energy_t refE;
    peoa_energy_t th2;
    peoa_energy_t th1;
    peoa_sample_t curS;
    logic signed [32:0] sq;
    logic [3:0] sbIdx;
    peoa_gain_t gLow;
    peoa_gain_t gHigh;
    peoa_gain_t gOld;
    logic stepStart;
    peoa_gain_t smoothLow;
    peoa_sample_t mixed;
    logic inhibNow;
    logic signed [41:0] dHigh;
    logic signed [41:0] dFull;
    logic [44:0] hSum;

    // sub-sub-block count and frame split
    always_comb begin
        ssfCount = rate8k ? 4'(`PEOA_NSSF_8K) : 4'(`PEOA_NSSF_WIDE);
        lssf = rate8k ? (subLen >> 2) : (subLen >> 3);
        frameLen = 10'(subLen * 10'(NSUB));
        memOnset = (onset_subblock_index == 4'(NSUB));
        j = 6'(cnt / 11'(lssf));
    end

    // regression check decided from envelopes
    always_comb begin
        logic [3:0] id;
        id = onset_subblock_index;
        dHigh = '0;
        dFull = '0;
        hSum = '0;
        inhibNow = 1'b0;
        if (id == 4'd2) begin
            dHigh = $signed({2'b0, highEnergy[1]}) - $signed({2'b0, highEnergy[0]});
            inhibNow = dHigh < 0;
        end else if (id > 4'd2 && id <= 4'(NSUB)) begin
            dFull = $signed({2'b0, fullEnergy[id-1]}) - $signed({2'b0, fullEnergy[id-3]});
            dHigh = $signed({2'b0, highEnergy[3'(id-1)]})
                - $signed({2'b0, highEnergy[3'(id-3)]});
            hSum = 45'(highEnergy[3'(id-1)]) + 45'(highEnergy[3'(id-2)])
                + 45'(highEnergy[3'(id-3)]);
            inhibNow = (dFull < 0)
                || (48'(dHigh) * 48'sd15 < $signed(48'(hSum) * 48'd2));
        end
    end

    // reference energy and thresholds for sub-sub-block j
    always_comb begin
        peoa_energy_t mcrit;
        peoa_energy_t q;
        logic [7:0] lim;
        lim = narrowBand ? 8'(`PEOA_ZCR_LIM_NB) : 8'(`PEOA_ZCR_LIM_WB);
        mcrit = 40'((64'(fullEnergy[onset_subblock_index - 4'd1])
            * lowInitGain[3'(onset_subblock_index - 4'd1)]) >> 15);
        if (peak_subblock_energy / `PEOA_MCRIT_DIV > mcrit
            && zcrCount[onset_subblock_index] > lim) begin
            mcrit = peak_subblock_energy / `PEOA_MCRIT_DIV;
        end
        refE = (onset_subblock_index == 4'd0) ? prevNoiseEnergy : mcrit;
        q = 40'((refE + 40'(`PEOA_SUM_MUL) * esum) / 40'(j + 6'd1));
        th2 = (q > prevNoiseEnergy) ? q : prevNoiseEnergy;
        th1 = eMax / `PEOA_PEAK_DIV;
    end

    // read sample for energy pass, in-frame or memory
    always_comb begin
        if (memOnset) begin
            curS = memBuf[cnt[6:0]];
        end else begin
            curS = fullBuf[10'(cnt) + 10'(onset_subblock_index) * subLen];
        end
        sq = 33'(curS) * 33'(curS);
    end

    // main sequencing state
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_acc = acc;
        next_esum = esum;
        next_eMax = eMax;
        next_nSsf = nSsf;
        next_onsetPos = onsetPos;
        next_stopAdv = stopAdv;
        next_inhib = inhib;
        next_lastGain = lastGain;
        case (state)
            PEOA_IDLE: begin
                if (frameStart) begin
                    next_state = PEOA_LOAD;
                    next_cnt = '0;
                end
            end
            PEOA_LOAD: begin
                if (inValid) begin
                    next_cnt = cnt + 11'd1;
                    if (cnt == 11'(frameLen) + 11'(subLen) - 11'd1) begin
                        next_state = PEOA_ENER;
                        next_cnt = '0;
                        next_acc = '0;
                        next_eMax = '0;
                        next_nSsf = (onset_subblock_index == 4'd0 || memOnset)
                            ? 7'(ssfCount)
                            : 7'(ssfCount) * 7'(4'(NSUB) - onset_subblock_index);
                        next_inhib = inhibNow;
                    end
                end
            end
            PEOA_ENER: begin
                next_cnt = cnt + 11'd1;
                next_acc = acc + 40'(sq);
                if (10'(cnt + 11'd1) % lssf == 10'd0) begin
                    next_acc = '0;
                    if (acc + 40'(sq) > eMax) begin
                        next_eMax = acc + 40'(sq);
                    end
                    if (6'(j) + 6'd1 == 6'(nSsf)) begin
                        next_state = PEOA_REFN;
                        next_cnt = '0;
                        next_esum = '0;
                        next_stopAdv = 1'b0;
                        next_onsetPos = memOnset ? frameLen
                            : 10'(onset_subblock_index) * subLen;
                    end
                end
            end
            PEOA_REFN: begin
                next_cnt = cnt + 11'(lssf);
                next_esum = esum + eshr[j];
                if (!stopAdv && eshr[j] < th1 && eshr[j] < th2) begin
                    next_onsetPos = onsetPos + lssf;
                end else begin
                    next_stopAdv = 1'b1;
                end
                if (6'(j) + 6'd1 == 6'(nSsf)) begin
                    next_state = PEOA_APPL;
                    next_cnt = '0;
                end
            end
            PEOA_APPL: begin
                next_cnt = cnt + 11'd1;
                if (cnt == 11'(frameLen) - 11'd1) begin
                    next_state = PEOA_IDLE;
                    next_lastGain = gLow;
                end
            end
            default: next_state = PEOA_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= PEOA_IDLE;
            cnt <= '0;
            acc <= '0;
            esum <= '0;
            eMax <= '0;
            nSsf <= '0;
            onsetPos <= '0;
            stopAdv <= 1'b0;
            inhib <= 1'b0;
            lastGain <= `PEOA_GAIN_RESET;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            acc <= next_acc;
            esum <= next_esum;
            eMax <= next_eMax;
            nSsf <= next_nSsf;
            onsetPos <= next_onsetPos;
            stopAdv <= next_stopAdv;
            inhib <= next_inhib;
            lastGain <= next_lastGain;
        end
    end

    // sample buffers and sub-sub-block energies
    always_ff @(posedge mclk) begin
        if (state == PEOA_LOAD && inValid) begin
            if (cnt < 11'(frameLen)) begin
                fullBuf[cnt[9:0]] <= fullSample;
                lowBuf[cnt[9:0]] <= lowband_signal;
                highBuf[cnt[9:0]] <= highband_signal;
            end else begin
                memBuf[7'(cnt - 11'(frameLen))] <= fullSample;
            end
        end
        if (state == PEOA_ENER && 10'(cnt + 11'd1) % lssf == 10'd0) begin
            eshr[j] <= acc + 40'(sq);
        end
    end

    // per-sample gains in the apply pass
    always_comb begin
        logic [3:0] lastPre;
        sbIdx = 4'(cnt / 11'(subLen));
        lastPre = onset_subblock_index - 4'd1;
        gLow = lowInitGain[sbIdx[2:0]];
        gHigh = highband_initial_gain[sbIdx[2:0]];
        gOld = (sbIdx == 4'd0) ? lastGain : lowInitGain[3'(sbIdx - 4'd1)];
        if (onset_subblock_index != 4'd0 && 10'(cnt) < onsetPos
            && sbIdx >= onset_subblock_index) begin
            gLow = lowInitGain[lastPre[2:0]];
            gHigh = highband_initial_gain[lastPre[2:0]];
            gOld = gLow;
        end
        stepStart = (10'(cnt) == 10'(sbIdx) * subLen && (sbIdx == 4'd0
            || 10'(cnt) >= onsetPos || sbIdx < onset_subblock_index))
            || (10'(cnt) == onsetPos && !memOnset);
        if (10'(cnt) == onsetPos && !memOnset && onset_subblock_index != 4'd0) begin
            gOld = lowInitGain[lastPre[2:0]];
        end
        if (inhib) begin
            gLow = `PEOA_GAIN_ONE;
            gHigh = `PEOA_GAIN_ONE;
            gOld = `PEOA_GAIN_ONE;
        end
    end

    peoa_gain_smoother u_smooth (
        .mclk(mclk),
        .reset(reset),
        .narrowBand(narrowBand),
        .stepStart(stepStart && state == PEOA_APPL),
        .sampleValid(state == PEOA_APPL),
        .oldGain(gOld),
        .newGain(gLow),
        .smoothGain(smoothLow)
    );

    peoa_mixer u_mix (
        .lowSample(lowBuf[cnt[9:0]]),
        .highSample(highBuf[cnt[9:0]]),
        .lowGain(smoothLow),
        .highGain(gHigh),
        .mixSample(mixed)
    );

    // registered outputs
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            busy <= 1'b0;
            outValid <= 1'b0;
            outSample <= '0;
            inhibit <= 1'b0;
            refinedOnset <= '0;
        end else begin
            busy <= next_state != PEOA_IDLE;
            outValid <= state == PEOA_APPL;
            outSample <= (state == PEOA_APPL) ? mixed : '0;
            inhibit <= inhib;
            refinedOnset <= onsetPos;
        end
    end

    property p_out_follows_apply;
        @(posedge mclk) disable iff (reset) (state == PEOA_APPL) |=> outValid;
    endproperty
    a_out_follows_apply: assert property (p_out_follows_apply)
        else $error("output valid missing in apply");

    property p_inhibit_unity;
        @(posedge mclk) disable iff (reset) (state == PEOA_APPL && inhib) |-> gHigh == 16'h7FFF;
    endproperty
    a_inhibit_unity: assert property (p_inhibit_unity)
        else $error("inhibited frame gain not unity");

    property p_early_no_inhibit;
        @(posedge mclk) disable iff (reset)
            (state == PEOA_LOAD && next_state == PEOA_ENER && onset_subblock_index < 4'd2)
            |=> !inhib;
    endproperty
    a_early_no_inhibit: assert property (p_early_no_inhibit)
        else $error("regression check applied to early onset");

    property p_onset_monotone;
        @(posedge mclk) disable iff (reset) (state == PEOA_REFN) |=> onsetPos >= $past(onsetPos);
    endproperty
    a_onset_monotone: assert property (p_onset_monotone)
        else $error("refined onset moved backwards");

    property p_third_block_drop;
        @(posedge mclk) disable iff (reset)
            (state == PEOA_LOAD && next_state == PEOA_ENER && onset_subblock_index == 4'd2
            && highEnergy[1] < highEnergy[0]) |=> inhib;
    endproperty
    a_third_block_drop: assert property (p_third_block_drop)
        else $error("third sub-block high band drop not inhibited");
endmodule

//--- sim/peoa_source.sv
// upstream sample source that streams one frame plus its memory samples
`timescale 1ns/10ps
module peoa_source
    import peoa_pkg::*;
(
    input wire logic mclk,
    input wire logic go,
    input wire logic [9:0] subLen,
    input wire logic [9:0] zeroStart,
    input wire logic [9:0] zeroLen,
    output logic frameStart,
    output logic inValid,
    output peoa_sample_t lowband_signal,
    output peoa_sample_t highband_signal,
    output peoa_sample_t fullSample
);
    int k;

    // idle levels at time zero
    initial begin
        frameStart = 1'b0;
        inValid = 1'b0;
        lowband_signal = 16'h0000;
        highband_signal = 16'h0000;
        fullSample = 16'h0000;
    end

    // start pulse, then eight sub-blocks and one memory sub-block back to back
    always @(posedge go) begin
        @(negedge mclk);
        frameStart = 1'b1;
        @(negedge mclk);
        frameStart = 1'b0;
        for (k = 0; k < 9 * subLen; k++) begin
            inValid = 1'b1;
            lowband_signal = 16'(k * 5 - 300);
            highband_signal = 16'(200 - k * 3);
            fullSample = (k >= zeroStart && k < zeroStart + zeroLen) ? 16'h0000 : 16'h1000;
            @(negedge mclk);
        end
        inValid = 1'b0;
        // released lines do not keep their last value
        lowband_signal = ~lowband_signal;
        highband_signal = ~highband_signal;
        fullSample = ~fullSample;
    end
endmodule

//--- sim/tb.sv
// self-checking testbench for the pre-echo onset refine and attenuate block
`timescale 1ns/10ps
module tb
    import peoa_pkg::*;
;
    logic mclk, reset, go, narrowBand, rate8k, frameStart, inValid;
    logic busy, outValid, inhibit;
    logic [9:0] subLen, zeroStart, zeroLen, refinedOnset;
    logic [3:0] onset_subblock_index;
    peoa_energy_t peak_subblock_energy, prevNoiseEnergy;
    peoa_energy_t fullEnergy [0:8];
    peoa_energy_t highEnergy [0:7];
    logic [7:0] zcrCount [0:8];
    peoa_gain_t lowInitGain [0:7];
    peoa_gain_t highband_initial_gain [0:7];
    peoa_sample_t lowband_signal, highband_signal, fullSample, outSample;
    peoa_sample_t got [$];
    int errors, comparisons;

    peoa_source src (.mclk(mclk), .go(go), .subLen(subLen), .zeroStart(zeroStart),
        .zeroLen(zeroLen), .frameStart(frameStart), .inValid(inValid),
        .lowband_signal(lowband_signal), .highband_signal(highband_signal),
        .fullSample(fullSample));

    peoa_top uut (.mclk(mclk), .reset(reset), .frameStart(frameStart),
        .narrowBand(narrowBand), .rate8k(rate8k), .subLen(subLen),
        .onset_subblock_index(onset_subblock_index),
        .peak_subblock_energy(peak_subblock_energy), .prevNoiseEnergy(prevNoiseEnergy),
        .fullEnergy(fullEnergy), .highEnergy(highEnergy), .zcrCount(zcrCount),
        .lowInitGain(lowInitGain), .highband_initial_gain(highband_initial_gain),
        .inValid(inValid), .lowband_signal(lowband_signal),
        .highband_signal(highband_signal), .fullSample(fullSample), .busy(busy),
        .outValid(outValid), .outSample(outSample), .inhibit(inhibit),
        .refinedOnset(refinedOnset));

    // clock at 100 ns period
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // output samples collected where settled
    always @(negedge mclk) begin
        if (outValid === 1'b1) begin
            got.push_back(outSample);
        end
    end

    task automatic check(input logic [39:0] seen, input logic [39:0] want);
        comparisons++;
        if (seen !== want) begin
            errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // expected sum of both gained bands for sample k
    function automatic peoa_sample_t mix(input int k, input int gl, input int gh);
        int acc;
        acc = (k * 5 - 300) * gl + (200 - k * 3) * gh;
        return peoa_sample_t'(acc >>> 15);
    endfunction

    // rising energies, unity low gains, half high gains
    task automatic defaults();
        for (int i = 0; i < 9; i++) begin
            fullEnergy[i] = 40'(i * 100);
            zcrCount[i] = 8'h00;
        end
        for (int i = 0; i < 8; i++) begin
            highEnergy[i] = 40'(i * i * 100);
            lowInitGain[i] = 16'h7FFF;
            highband_initial_gain[i] = 16'h4000;
        end
    endtask

    // one frame through the source, bounded wait for the block to go idle
    task automatic run_frame(input logic [3:0] idx, input logic r8, input int zs, input int zl);
        int n;
        n = 0;
        onset_subblock_index = idx;
        rate8k = r8;
        zeroStart = 10'(zs);
        zeroLen = 10'(zl);
        got.delete();
        go = 1'b1;
        @(negedge mclk);
        go = 1'b0;
        while (busy !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        while (busy !== 1'b0 && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        check(busy, 1'b0);
        @(negedge mclk);
    endtask

    task automatic check_out(input int gl, input int gh);
        check(got.size(), 128);
        for (int k = 0; k < got.size(); k++) begin
            check(got[k], mix(k, gl, gh));
        end
    endtask

    // falling high band before an early onset
    task automatic test_early_onset();
        highEnergy[0] = 40'h00000001F4;
        fullEnergy[0] = 40'h0000000384;
        run_frame(4'h1, 1'b0, 0, 0);
        check(inhibit, 1'b0);
        run_frame(4'h2, 1'b0, 0, 0);
        check(inhibit, 1'b1);
        defaults();
    endtask

    // falling full band three blocks back, whole frame at unity
    task automatic test_full_slope();
        fullEnergy[4] = 40'h0000000000;
        run_frame(4'h5, 1'b0, 0, 0);
        check(inhibit, 1'b1);
        check_out(32767, 32767);
        defaults();
    endtask

    // normalised high band slope on both sides of two fifteenths
    task automatic test_high_slope();
        highEnergy[1] = 40'h0000000000;
        highEnergy[3] = 40'h0000000002;
        highEnergy[2] = 40'h000000000D;
        run_frame(4'h4, 1'b0, 0, 0);
        check(inhibit, 1'b0);
        highEnergy[2] = 40'h000000000E;
        run_frame(4'h4, 1'b0, 0, 0);
        check(inhibit, 1'b1);
        defaults();
    endtask

    // onset in memory: no advance, no smoothing, high gain unsmoothed
    task automatic test_memory_onset();
        narrowBand = 1'b1;
        run_frame(4'h8, 1'b0, 0, 0);
        check(inhibit, 1'b0);
        check(refinedOnset, 10'h080);
        check_out(32767, 16384);
        narrowBand = 1'b0;
    endtask

    // six quiet samples at the onset advance by whole sub-sub-blocks only
    task automatic test_refine();
        lowInitGain[3] = 16'h0000;
        run_frame(4'h4, 1'b0, 64, 6);
        check(inhibit, 1'b0);
        check(refinedOnset, 10'h046);
        check(got[49], mix(49, 3 * 32767 / 5, 16384));
        check(got[60], mix(60, 0, 16384));
        check(got[66], mix(66, 0, 16384));
        check(got[71], mix(71, 2 * 32767 / 5, 16384));
        check(got[74], mix(74, 32767, 16384));
        run_frame(4'h4, 1'b1, 64, 6);
        check(refinedOnset, 10'h044);
        defaults();
    endtask

    // watchdog sized well above the few thousand cycles the frames need
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        conclude();
    end

    // reset, then the scenarios in order
    initial begin
        errors = 0;
        comparisons = 0;
        reset = 1'b1;
        go = 1'b0;
        narrowBand = 1'b0;
        rate8k = 1'b0;
        subLen = 10'h010;
        zeroStart = 10'h000;
        zeroLen = 10'h000;
        onset_subblock_index = 4'h0;
        peak_subblock_energy = 40'h0000F00000;
        prevNoiseEnergy = 40'h0000000001;
        defaults();
        repeat (8) @(negedge mclk);
        reset = 1'b0;
        check(busy, 1'b0);
        test_early_onset();
        test_full_slope();
        test_high_slope();
        test_memory_onset();
        test_refine();
        conclude();
    end
endmodule
